/* File: common/dswp_pkg.sv */
package dswp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int DSWP_FRAME_BITS = 16;
  localparam int DSWP_CNT_W = 5;
  localparam logic [DSWP_CNT_W-1:0] DSWP_LAST_BIT = 5'h0F;
  localparam int DSWP_DATA_W = 10;
  localparam int DSWP_DATA_LSB = 2;
  localparam int DSWP_DATA_MSB = 11;
  localparam int DSWP_MODE_HI = 13;
  localparam int DSWP_MODE_LO = 12;
  localparam logic [DSWP_DATA_W-1:0] DSWP_DATA_RST = 10'h000;
  localparam logic [1:0] DSWP_MODE_RST = 2'h0;
  localparam logic [DSWP_FRAME_BITS-1:0] DSWP_SHIFT_RST = 16'h0000;
  localparam logic [DSWP_CNT_W-1:0] DSWP_CNT_RST = 5'h00;
  localparam logic [DSWP_CNT_W-1:0] DSWP_CNT_STEP = 5'h01;
  // Synchronised pins reset to select high, clock and data low
  localparam logic [2:0] DSWP_SYNC_RST = 3'h4;
  localparam logic DSWP_SCLK_RST = 1'b0;

  typedef struct packed {
    logic power_mode_bit_hi;
    logic power_mode_bit_lo;
    logic [DSWP_DATA_W-1:0] code;
  } dswp_word_s;

  typedef enum logic [2:0] {
    DSWP_IDLE = 3'h1,
    DSWP_SHIFT = 3'h2,
    DSWP_DONE = 3'h4
  } dswp_state_e;

endpackage

/* File: rtl/dswp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dswp_sync
  import dswp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);
  logic [2:0] meta_reg;
  logic [2:0] meta_next;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  always_comb begin
    meta_next = meta_reg;
    sync_next = sync_reg;
    if (srst_in) begin
      meta_next = DSWP_SYNC_RST;
      sync_next = DSWP_SYNC_RST;
    end else if (ce_in) begin
      meta_next = async_in;
      sync_next = meta_reg;
    end
  end

  always_ff @(posedge core_clk_in) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

/* File: rtl/dswp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module dswp_port
  import dswp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic frame_sel_n_in,
  input wire logic shift_clk_in,
  input wire logic serial_data_in,
  output logic [DSWP_DATA_W-1:0] dac_code_out,
  output logic power_mode_bit_hi_out,
  output logic power_mode_bit_lo_out,
  output logic update_out,
  output logic abort_out
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;
  logic sel_n;
  logic sclk;
  logic din;

  dswp_sync u_sync (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .async_in({frame_sel_n_in, shift_clk_in, serial_data_in}),
    .sync_out(pins_sync)
  );

  assign sel_n = pins_sync[2];
  assign sclk = pins_sync[1];
  assign din = pins_sync[0];

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // True while a frame is being shifted in
  function automatic logic is_shifting(input dswp_state_e st);
    is_shifting = (st == DSWP_SHIFT);
  endfunction

  // True when the counter points at the last bit of a frame
  function automatic logic last_bit(
    input logic [DSWP_CNT_W-1:0] cnt
  );
    last_bit = (cnt == DSWP_LAST_BIT);
  endfunction

  // Splits a full frame into mode bits and converter code
  function automatic dswp_word_s unpack_frame(
    input logic [DSWP_FRAME_BITS-1:0] frame
  );
    dswp_word_s word;
    word.power_mode_bit_hi = frame[DSWP_MODE_HI];
    word.power_mode_bit_lo = frame[DSWP_MODE_LO];
    word.code = frame[DSWP_DATA_MSB:DSWP_DATA_LSB];
    return word;
  endfunction

  // ----------------------------------------------------------------
  // Shift clock edge detector
  // ----------------------------------------------------------------
  logic sclk_d_reg;
  logic sclk_d_next;
  logic fall;

  always_comb begin
    sclk_d_next = sclk;
    // Reset low, like the synchronised clock, so release gives no false fall
    if (srst_in) begin
      sclk_d_next = DSWP_SCLK_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (ce_in || srst_in) begin
      sclk_d_reg <= sclk_d_next;
    end
  end

  // Only a high-to-low step of the sampled shift clock moves a bit
  assign fall = sclk_d_reg & ~sclk;

  // ----------------------------------------------------------------
  // Frame control
  // ----------------------------------------------------------------
  dswp_state_e state_reg;
  dswp_state_e state_next;
  logic [DSWP_FRAME_BITS-1:0] shift_reg;
  logic [DSWP_FRAME_BITS-1:0] shift_next;
  logic [DSWP_FRAME_BITS-1:0] shift_in;
  logic [DSWP_CNT_W-1:0] cnt_reg;
  logic [DSWP_CNT_W-1:0] cnt_next;
  logic shift_en;
  logic frame_end;
  logic frame_abort;

  // First bit lands in the top position after sixteen shifts
  assign shift_in = {shift_reg[DSWP_FRAME_BITS-2:0], din};
  assign shift_en = is_shifting(state_reg) && fall;
  assign frame_end = shift_en && last_bit(cnt_reg);
  // Select may rise together with the last fall; that fall still counts,
  // so an abort is only taken when no fall is pending
  assign frame_abort = is_shifting(state_reg) && !fall && sel_n;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      DSWP_IDLE: begin
        if (!sel_n) begin
          state_next = DSWP_SHIFT;
          shift_next = DSWP_SHIFT_RST;
          cnt_next = DSWP_CNT_RST;
        end
      end
      DSWP_SHIFT: begin
        if (shift_en) begin
          // Counter and shift register move together on each taken fall
          shift_next = shift_in;
          cnt_next = cnt_reg + DSWP_CNT_STEP;
          if (frame_end) begin
            state_next = DSWP_DONE;
          end
        end else if (frame_abort) begin
          state_next = DSWP_IDLE;
          shift_next = DSWP_SHIFT_RST;
          cnt_next = DSWP_CNT_RST;
        end
      end
      DSWP_DONE: begin
        // Further falls are ignored until select has been high
        if (sel_n) begin
          state_next = DSWP_IDLE;
        end
      end
      default: begin
        state_next = DSWP_IDLE;
      end
    endcase
    if (srst_in) begin
      state_next = DSWP_IDLE;
      shift_next = DSWP_SHIFT_RST;
      cnt_next = DSWP_CNT_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (ce_in || srst_in) begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Converter register
  // ----------------------------------------------------------------
  dswp_word_s word_reg;
  dswp_word_s word_next;

  always_comb begin
    word_next = word_reg;
    if (frame_end) begin
      word_next = unpack_frame(shift_in);
    end
    if (srst_in) begin
      word_next = {DSWP_MODE_RST, DSWP_DATA_RST};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (ce_in || srst_in) begin
      word_reg <= word_next;
    end
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  logic update_reg;
  logic update_next;
  logic abort_reg;
  logic abort_next;

  always_comb begin
    update_next = 1'b0;
    abort_next = 1'b0;
    if (frame_end) begin
      update_next = 1'b1;
    end
    // A cut frame only raises this pulse; mode and code stay put
    if (frame_abort) begin
      abort_next = 1'b1;
    end
    if (srst_in) begin
      update_next = 1'b0;
      abort_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (ce_in || srst_in) begin
      update_reg <= update_next;
      abort_reg <= abort_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dac_code_out = word_reg.code;
  assign power_mode_bit_hi_out = word_reg.power_mode_bit_hi;
  assign power_mode_bit_lo_out = word_reg.power_mode_bit_lo;
  assign update_out = update_reg;
  assign abort_out = abort_reg;
endmodule
`default_nettype wire

/* File: testbench/dswp_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dswp_port_checker
  import dswp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic frame_sel_n_in,
  input wire logic shift_clk_in,
  input wire logic serial_data_in,
  input wire logic [DSWP_DATA_W-1:0] dac_code_out,
  input wire logic power_mode_bit_hi_out,
  input wire logic power_mode_bit_lo_out,
  input wire logic update_out,
  input wire logic abort_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  AST_UPD_ONE: assert property (update_out |=> !update_out)
    else $error("update long");
  AST_ABT_ONE: assert property (abort_out |=> !abort_out)
    else $error("abort long");
  AST_CODE_CHG: assert property ($changed(dac_code_out) |-> update_out)
    else $error("code moved");
  AST_MODE_CHG: assert property ($changed({power_mode_bit_hi_out,
    power_mode_bit_lo_out}) |-> update_out) else $error("mode moved");
  AST_RST_ZERO: assert property ($past(srst_in) |-> dac_code_out == 10'h000)
    else $error("code not cleared");
  AST_ABT_SEL: assert property (abort_out |-> frame_sel_n_in)
    else $error("abort with select low");
  AST_UPD_SEL: assert property (update_out |-> $past(!frame_sel_n_in, 4))
    else $error("update with select high");
  AST_NO_BOTH: assert property (!(update_out && abort_out))
    else $error("update and abort");
endmodule
bind dswp_port dswp_port_checker chk_u (.core_clk_in, .srst_in, .ce_in,
  .frame_sel_n_in, .shift_clk_in, .serial_data_in, .dac_code_out,
  .power_mode_bit_hi_out, .power_mode_bit_lo_out, .update_out, .abort_out);
`default_nettype wire

/* File: testbench/dswp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dswp_host_model (
  output logic frame_sel_n_out,
  output logic shift_clk_out,
  output logic serial_data_out
);
  initial begin
    frame_sel_n_out = 1'b1;
    shift_clk_out = 1'b1;
    serial_data_out = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int nb);
    frame_sel_n_out = 1'b0;
    #20;
    for (int i = 15; i > 15 - nb; i--) begin
      shift_clk_out = 1'b1;
      serial_data_out = w[i];
      #40 shift_clk_out = 1'b0;
      #40;
    end
    shift_clk_out = 1'b1;
    #40 frame_sel_n_out = 1'b1;
    serial_data_out = ~serial_data_out;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_dac_serial_write_port.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dac_serial_write_port;
  import dswp_pkg::*;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic sel_n, sclk, sdi, m_hi, m_lo, upd, abt;
  logic [DSWP_DATA_W-1:0] code;
  logic [15:0] w;
  logic [11:0] exp_out = 12'h000;
  logic [11:0] exp_q[$];
  int n_errors = 0, checks = 0, n_upd = 0, n_abt = 0, eu, ea, nb;
  always #2 core_clk_in = ~core_clk_in;
  always @(negedge core_clk_in) begin
    n_upd <= n_upd + (upd === 1'b1);
    n_abt <= n_abt + (abt === 1'b1);
  end
  dswp_host_model host_u (.frame_sel_n_out(sel_n), .shift_clk_out(sclk),
    .serial_data_out(sdi));
  dswp_port dut_u (.core_clk_in, .srst_in, .ce_in(1'b1), .frame_sel_n_in(sel_n),
    .shift_clk_in(sclk), .serial_data_in(sdi), .dac_code_out(code),
    .power_mode_bit_hi_out(m_hi), .power_mode_bit_lo_out(m_lo),
    .update_out(upd), .abort_out(abt));
  task automatic check(input string s, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic check_word(input string s, input logic [11:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(negedge core_clk_in) begin
    if (upd === 1'b1) begin
      check("queued words", 16'h0001, 16'(exp_q.size() != 0));
      if (exp_q.size() != 0) begin
        check_word("pulse", exp_q.pop_front(), {m_hi, m_lo, code});
      end
    end
  end
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h36D0));
    repeat (2) @(posedge core_clk_in);
    #1 srst_in = 1'b0;
    check_word("reset", 12'h000, {m_hi, m_lo, code});
    for (int i = 0; i < 12; i++) begin
      w = 16'($urandom);
      nb = (i % 3 == 1) ? 15 - i / 3 * 4 : 16;
      eu = n_upd + (nb == 16);
      ea = n_abt + (nb < 16);
      if (nb == 16) begin
        exp_out = {w[13:12], w[11:2]};
        exp_q.push_back(exp_out);
      end
      host_u.send(w, nb);
      check("updates", 16'(eu), 16'(n_upd));
      check("aborts", 16'(ea), 16'(n_abt));
      check_word("outputs", exp_out, {m_hi, m_lo, code});
      $display("test %0d done", i);
    end
    check("queue drained", 16'h0000, 16'(exp_q.size()));
    complete_run();
  end
endmodule
`default_nettype wire
